// ==== rtl/fieldbus_led_pkg.sv ====
// Package: states, timing constants and carrier structs for the fieldbus node status LED.
// Assumes a 50 MHz system clock and event inputs already in that clock domain.
package fieldbus_led_pkg;

   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned TICK_MS         = 50;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TICK_W          = 22;

   // Pattern timing in ms, converted to ticks
   localparam int unsigned FLASH_ON_MS     = 200;
   localparam int unsigned FLASH_GAP_MS    = 1000;
   localparam int unsigned ERR_SHORT_MS    = 150;
   localparam int unsigned ERR_LONG_MS     = 600;
   localparam int unsigned ERR_GAP_MS      = 300;
   localparam int unsigned ERR_PAUSE_MS    = 2000;
   localparam logic [5:0]  FLASH_ON_TICKS  = 6'(FLASH_ON_MS / TICK_MS);
   localparam logic [5:0]  FLASH_GAP_TICKS = 6'(FLASH_GAP_MS / TICK_MS);
   localparam logic [5:0]  ERR_SHORT_TICKS = 6'(ERR_SHORT_MS / TICK_MS);
   localparam logic [5:0]  ERR_LONG_TICKS  = 6'(ERR_LONG_MS / TICK_MS);
   localparam logic [5:0]  ERR_GAP_TICKS   = 6'(ERR_GAP_MS / TICK_MS);
   localparam logic [5:0]  ERR_PAUSE_TICKS = 6'(ERR_PAUSE_MS / TICK_MS);
   localparam logic [1:0]  ERR_LAST_PHASE  = 2'h3;

   // Reset values
   localparam logic [15:0] TIMEOUT_RST     = 16'h0000;
   localparam logic [5:0]  CNT_RST         = 6'h00;

   typedef enum logic [6:0] {
      ST_INACTIVE = 7'h01,
      ST_PLAIN    = 7'h02,
      ST_PREOP1   = 7'h04,
      ST_PREOP2   = 7'h08,
      ST_READY    = 7'h10,
      ST_RUNNING  = 7'h20,
      ST_HALTED   = 7'h40
   } node_state_e;

   // Command pulses from the node protocol engine
   typedef struct packed {
      logic cycle_start;
      logic ready;
      logic operate;
      logic stop;
      logic preop;
   } node_cmd_s;

   // Per-state data path controls
   typedef struct packed {
      logic ip_mode;
      logic cfg_accept;
      logic reduced_cycle;
      logic cyclic_en;
      logic pdo_tx_en;
      logic rx_eval;
      logic rx_discard;
   } node_ctrl_s;

endpackage

// ==== rtl/fieldbus_node_led.sv ====
// Node state machine and status LED driver for a real-time Ethernet fieldbus port.
// Assumes all event and config inputs come from logic on sys_clk_i; role and mode are static.
`timescale 1ns/1ps
module fieldbus_node_led #(
   parameter int unsigned TICK_CYCLES = fieldbus_led_pkg::TICK_CYCLES
)(
   // Clock and reset
   input  wire logic                         sys_clk_i,
   input  wire logic                         rst_i,
   // Configuration
   input  wire logic                         eth_mode_i,
   input  wire logic                         managing_node_role_i,
   input  wire logic [15:0]                  timeout_ticks_i,
   // Bus events
   input  wire logic                         frame_seen_i,
   input  wire logic                         soc_rx_i,
   input  wire fieldbus_led_pkg::node_cmd_s  cmd_i,
   input  wire logic                         mn_fail_i,
   // System stop error
   input  wire logic                         sys_err_i,
   input  wire logic [3:0]                   err_code_i,
   // Indicator and status
   output logic                              led_green_o,
   output logic                              led_red_o,
   output fieldbus_led_pkg::node_state_e     state_o,
   output fieldbus_led_pkg::node_ctrl_s      ctrl_o
);

   typedef fieldbus_led_pkg::node_state_e st_t;

   st_t         st_ff;
   st_t         nxt_st;
   logic [21:0] div_ff;
   logic        tick_ff;
   logic [2:0]  fr_ff;
   logic [15:0] to_cnt_ff;
   logic        block_ff;
   logic [5:0]  pat_ff;
   logic [5:0]  err_cnt_ff;
   logic [1:0]  err_idx_ff;
   logic        err_on_ff;
   logic        green_ff;
   logic        red_ff;
   fieldbus_led_pkg::node_ctrl_s ctrl_ff;

   function automatic logic [1:0] flash_count(input st_t s);
      flash_count = (s == fieldbus_led_pkg::ST_PREOP1) ? 2'h1 :
                    (s == fieldbus_led_pkg::ST_PREOP2) ? 2'h2 :
                    (s == fieldbus_led_pkg::ST_READY)  ? 2'h3 : 2'h0;
   endfunction

   function automatic logic in_st(input st_t s, input st_t t);
      in_st = (s == t);
   endfunction

   // Timebase; one tick per 50 ms
   wire div_end = (div_ff == 22'(TICK_CYCLES - 1));

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         div_ff  <= 22'h000000;
         tick_ff <= 1'b0;
         fr_ff   <= 3'h0;
      end
      else
      begin
         div_ff  <= div_end ? 22'h000000 : div_ff + 22'h000001;
         tick_ff <= div_end;
         fr_ff   <= fr_ff + {2'h0, tick_ff};
      end
   end

   wire is_mn       = managing_node_role_i;
   wire timeout_hit = (to_cnt_ff >= timeout_ticks_i);

   // Next state; traffic seen in the same cycle as timeout wins
   always_comb
   begin
      nxt_st = st_ff;
      unique case (st_ff)
         fieldbus_led_pkg::ST_INACTIVE:
            if (is_mn)
            begin
               if (!block_ff && !frame_seen_i && timeout_hit)
                  nxt_st = fieldbus_led_pkg::ST_PREOP1;
            end
            else if (frame_seen_i)
               nxt_st = fieldbus_led_pkg::ST_PREOP1;
            else if (timeout_hit)
               nxt_st = fieldbus_led_pkg::ST_PLAIN;
         fieldbus_led_pkg::ST_PLAIN:
            if (!is_mn && frame_seen_i)
               nxt_st = fieldbus_led_pkg::ST_PREOP1;
         fieldbus_led_pkg::ST_PREOP1:
            if (is_mn ? cmd_i.cycle_start : soc_rx_i)
               nxt_st = fieldbus_led_pkg::ST_PREOP2;
         fieldbus_led_pkg::ST_PREOP2:
            if (cmd_i.ready)
               nxt_st = fieldbus_led_pkg::ST_READY;
         fieldbus_led_pkg::ST_READY:
            if (cmd_i.operate)
               nxt_st = fieldbus_led_pkg::ST_RUNNING;
         fieldbus_led_pkg::ST_RUNNING:
            if (!is_mn && cmd_i.stop)
               nxt_st = fieldbus_led_pkg::ST_HALTED;
         fieldbus_led_pkg::ST_HALTED:
            if (cmd_i.preop)
               nxt_st = fieldbus_led_pkg::ST_PREOP2;
         default:
            nxt_st = fieldbus_led_pkg::ST_INACTIVE;
      endcase
   end

   // Timeout window and foreign-traffic lock
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_ff     <= fieldbus_led_pkg::ST_INACTIVE;
         to_cnt_ff <= fieldbus_led_pkg::TIMEOUT_RST;
         block_ff  <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
         if (tick_ff && !timeout_hit)
            to_cnt_ff <= to_cnt_ff + 16'h0001;
         if (is_mn && in_st(st_ff, fieldbus_led_pkg::ST_INACTIVE) && frame_seen_i && !timeout_hit)
            block_ff <= 1'b1;
      end
   end

   // Flash pattern position, restarted on any state change
   wire [1:0] n_flash = flash_count(st_ff);
   wire [5:0] pat_len = {1'b0, n_flash, 3'h0} + fieldbus_led_pkg::FLASH_GAP_TICKS;
   wire       pat_end = (pat_ff >= pat_len - 6'h01);

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         pat_ff <= fieldbus_led_pkg::CNT_RST;
      else if (nxt_st != st_ff)
         pat_ff <= fieldbus_led_pkg::CNT_RST;
      else if (tick_ff)
         pat_ff <= pat_end ? fieldbus_led_pkg::CNT_RST : pat_ff + 6'h01;
   end

   // Flash on while inside n periods and in the first half of each
   wire flash_on = (pat_ff < {1'b0, n_flash, 3'h0}) &&
                   (pat_ff[2:0] < fieldbus_led_pkg::FLASH_ON_TICKS[2:0]);

   // System stop error sequencer
   wire [5:0] err_on_len  = err_code_i[err_idx_ff] ? fieldbus_led_pkg::ERR_LONG_TICKS
                                                   : fieldbus_led_pkg::ERR_SHORT_TICKS;
   wire [5:0] err_off_len = (err_idx_ff == fieldbus_led_pkg::ERR_LAST_PHASE) ? fieldbus_led_pkg::ERR_PAUSE_TICKS
                                                                             : fieldbus_led_pkg::ERR_GAP_TICKS;
   wire [5:0] err_len     = err_on_ff ? err_on_len : err_off_len;
   wire       err_end     = (err_cnt_ff >= err_len - 6'h01);

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         err_cnt_ff <= fieldbus_led_pkg::CNT_RST;
         err_idx_ff <= 2'h0;
         err_on_ff  <= 1'b1;
      end
      else if (!sys_err_i)
      begin
         err_cnt_ff <= fieldbus_led_pkg::CNT_RST;
         err_idx_ff <= 2'h0;
         err_on_ff  <= 1'b1;
      end
      else if (tick_ff)
      begin
         err_cnt_ff <= err_end ? fieldbus_led_pkg::CNT_RST : err_cnt_ff + 6'h01;
         if (err_end)
         begin
            err_on_ff <= !err_on_ff;
            if (!err_on_ff)
               err_idx_ff <= err_idx_ff + 2'h1;
         end
      end
   end

   // Indicator selection
   wire cn_watch   = !is_mn && (in_st(st_ff, fieldbus_led_pkg::ST_PREOP1) ||
                                in_st(st_ff, fieldbus_led_pkg::ST_PREOP2) ||
                                in_st(st_ff, fieldbus_led_pkg::ST_READY));
   wire nxt_red    = sys_err_i ? err_on_ff : (cn_watch && mn_fail_i);
   wire nxt_green  = eth_mode_i ? 1'b1 :
                     (st_ff == fieldbus_led_pkg::ST_INACTIVE) ? 1'b0 :
                     (st_ff == fieldbus_led_pkg::ST_PLAIN)    ? fr_ff[0] :
                     (st_ff == fieldbus_led_pkg::ST_RUNNING)  ? 1'b1 :
                     (st_ff == fieldbus_led_pkg::ST_HALTED)   ? fr_ff[2] : flash_on;

   // Data path controls per state and role
   fieldbus_led_pkg::node_ctrl_s nxt_ctrl;
   wire in_pre2  = in_st(st_ff, fieldbus_led_pkg::ST_PREOP2);
   wire in_ready = in_st(st_ff, fieldbus_led_pkg::ST_READY);
   wire in_run   = in_st(st_ff, fieldbus_led_pkg::ST_RUNNING);

   assign nxt_ctrl.ip_mode       = eth_mode_i || in_st(st_ff, fieldbus_led_pkg::ST_PLAIN);
   assign nxt_ctrl.cfg_accept    = !is_mn && (in_st(st_ff, fieldbus_led_pkg::ST_PREOP1) || in_pre2);
   assign nxt_ctrl.reduced_cycle = is_mn && in_st(st_ff, fieldbus_led_pkg::ST_PREOP1);
   assign nxt_ctrl.cyclic_en     = in_pre2 || in_ready || in_run;
   assign nxt_ctrl.pdo_tx_en     = in_ready || in_run;
   assign nxt_ctrl.rx_eval       = in_run;
   assign nxt_ctrl.rx_discard    = is_mn && (in_pre2 || in_ready);

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         green_ff <= 1'b0;
         red_ff   <= 1'b0;
         ctrl_ff  <= '0;
      end
      else
      begin
         green_ff <= nxt_green;
         red_ff   <= nxt_red;
         ctrl_ff  <= nxt_ctrl;
      end
   end

   assign led_green_o = green_ff;
   assign led_red_o   = red_ff;
   assign state_o     = st_ff;
   assign ctrl_o      = ctrl_ff;

   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_cn_soc;
      !is_mn && st_ff == fieldbus_led_pkg::ST_PREOP1 && soc_rx_i;
   endsequence

   sequence s_cn_idle_timeout;
      !is_mn && st_ff == fieldbus_led_pkg::ST_INACTIVE && timeout_hit && !frame_seen_i;
   endsequence

   a_eth_green_on: assert property (eth_mode_i |=> led_green_o)
      else $error("green not lit in Ethernet mode");
   a_inactive_dark: assert property (st_ff == fieldbus_led_pkg::ST_INACTIVE && !eth_mode_i |=> !led_green_o)
      else $error("green lit while inactive");
   a_mn_timeout_start: assert property (is_mn && st_ff == fieldbus_led_pkg::ST_INACTIVE && !block_ff
                                        && timeout_hit && !frame_seen_i |=> st_ff == fieldbus_led_pkg::ST_PREOP1)
      else $error("manager did not start after timeout");
   a_mn_blocked_stays: assert property (is_mn && block_ff |-> st_ff == fieldbus_led_pkg::ST_INACTIVE)
      else $error("manager started despite foreign traffic");
   a_cn_timeout_plain: assert property (s_cn_idle_timeout |=> st_ff == fieldbus_led_pkg::ST_PLAIN)
      else $error("controlled node missed plain Ethernet entry");
   a_cn_traffic_pre1: assert property (!is_mn && st_ff == fieldbus_led_pkg::ST_INACTIVE && frame_seen_i
                                       |=> st_ff == fieldbus_led_pkg::ST_PREOP1)
      else $error("controlled node missed first pre-op entry");
   a_mn_plain_locked: assert property (is_mn && st_ff == fieldbus_led_pkg::ST_PLAIN |=> $stable(st_ff))
      else $error("manager left plain Ethernet state");
   a_cn_plain_exit: assert property (!is_mn && st_ff == fieldbus_led_pkg::ST_PLAIN && frame_seen_i
                                     |=> st_ff == fieldbus_led_pkg::ST_PREOP1)
      else $error("plain Ethernet exit missed");
   a_cn_soc_pre2: assert property (s_cn_soc |=> st_ff == fieldbus_led_pkg::ST_PREOP2 ##1 ctrl_o.cyclic_en)
      else $error("start-of-cycle did not reach second pre-op");
   a_red_mn_fail: assert property (cn_watch && mn_fail_i && !sys_err_i |=> led_red_o)
      else $error("red not lit on manager failure");
   a_cn_ready_cmd: assert property (!is_mn && st_ff == fieldbus_led_pkg::ST_PREOP2 && cmd_i.ready
                                    |=> st_ff == fieldbus_led_pkg::ST_READY ##1 ctrl_o.pdo_tx_en && !ctrl_o.rx_eval)
      else $error("ready command mishandled");
   a_run_green: assert property (st_ff == fieldbus_led_pkg::ST_RUNNING && !eth_mode_i |=> led_green_o)
      else $error("green not lit while running");
   a_mn_never_halt: assert property (is_mn && st_ff != fieldbus_led_pkg::ST_HALTED
                                     |=> st_ff != fieldbus_led_pkg::ST_HALTED)
      else $error("manager reached halted state");
   a_halt_holds: assert property (st_ff == fieldbus_led_pkg::ST_HALTED && !cmd_i.preop |=> $stable(st_ff)
                                  ##1 !ctrl_o.pdo_tx_en)
      else $error("halted state left without command");
   a_err_red_on: assert property ($rose(sys_err_i) |=> led_red_o)
      else $error("error code did not start with red phase");

   // Plain flicker checked over one tick with no frame that could move the state
   sequence s_plain_tick;
      !eth_mode_i && st_ff == fieldbus_led_pkg::ST_PLAIN && !frame_seen_i && tick_ff;
   endsequence

   a_plain_flicker: assert property (s_plain_tick |=> ##1 led_green_o != $past(led_green_o))
      else $error("green did not flicker in plain Ethernet state");
   a_mn_pre1_reduced: assert property (is_mn && st_ff == fieldbus_led_pkg::ST_PREOP1
                                       |=> ctrl_o.reduced_cycle && !ctrl_o.cyclic_en)
      else $error("manager first pre-op controls wrong");
   a_mn_ready_discard: assert property (is_mn && st_ff == fieldbus_led_pkg::ST_READY
                                        |=> ctrl_o.rx_discard && !ctrl_o.rx_eval)
      else $error("manager kept received process data in ready");
   // A lit gap would read as one flash too many
   a_flash_gap_dark: assert property (!eth_mode_i && n_flash != 2'h0 && pat_ff >= {1'b0, n_flash, 3'h0}
                                      |=> !led_green_o)
      else $error("green lit in flash gap");
   a_err_gap_dark: assert property (sys_err_i && !err_on_ff |=> !led_red_o)
      else $error("red lit between error phases");

endmodule // fieldbus_node_led

// ==== sim/fieldbus_peer_model.sv ====
// Behavioural model of the managing node and bus traffic seen by the node.
// Assumes the bench calls its tasks; outputs move 1 ns after a rising edge.
`timescale 1ns/1ps
module fieldbus_peer_model (
   // Clock
   input  wire logic                     sys_clk_i,
   // Events toward the node
   output logic                          frame_seen_o,
   output logic                          soc_rx_o,
   output fieldbus_led_pkg::node_cmd_s   cmd_o,
   output logic                          mn_fail_o
);
   initial
   begin
      {frame_seen_o, soc_rx_o, cmd_o} = 7'h00;
      mn_fail_o = 1'b0;
   end

   // One-cycle event pulse {frame, soc, cmd}; manager sends SoC and state commands
   task automatic pulse(input logic [6:0] ev);
      @(posedge sys_clk_i);
      #1;
      {frame_seen_o, soc_rx_o, cmd_o} = ev;
      @(posedge sys_clk_i);
      #1;
      {frame_seen_o, soc_rx_o, cmd_o} = 7'h00;
   endtask

   // Manager failure is a level
   task automatic set_fail(input logic f);
      mn_fail_o = f;
   endtask
endmodule // fieldbus_peer_model

// ==== sim/tb_fieldbus_node_led.sv ====
// Self-checking bench for the fieldbus node state and LED block.
// Assumes a short tick (4 cycles) so that flash periods stay brief.
`timescale 1ns/1ps
module tb_fieldbus_node_led;
   localparam int T = 4;
   localparam logic [6:0] EV_FRAME = 7'h40, EV_SOC = 7'h20, EV_CYC = 7'h10, EV_RDY = 7'h08;
   localparam logic [6:0] EV_OP = 7'h04, EV_STOP = 7'h02, EV_PRE = 7'h01;
   logic                        sys_clk_i = 1'b0;
   logic                        rst_i = 1'b1;
   logic                        eth_mode_i = 1'b0;
   logic                        managing_node_role_i = 1'b0;
   logic [15:0]                 timeout_ticks_i = 16'h0003;
   logic                        frame_seen_i;
   logic                        soc_rx_i;
   fieldbus_led_pkg::node_cmd_s cmd_i;
   logic                        mn_fail_i;
   logic                        sys_err_i = 1'b0;
   logic [3:0]                  err_code_i = 4'h5;
   logic                        led_green_o;
   logic                        led_red_o;
   fieldbus_led_pkg::node_state_e state_o;
   fieldbus_led_pkg::node_ctrl_s  ctrl_o;
   int                          mismatches = 0;
   int                          check_count = 0;

   always #10 sys_clk_i = ~sys_clk_i;

   fieldbus_node_led #(.TICK_CYCLES(T)) fieldbus_node_led_inst (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .eth_mode_i(eth_mode_i),
      .managing_node_role_i(managing_node_role_i), .timeout_ticks_i(timeout_ticks_i),
      .frame_seen_i(frame_seen_i), .soc_rx_i(soc_rx_i), .cmd_i(cmd_i), .mn_fail_i(mn_fail_i),
      .sys_err_i(sys_err_i), .err_code_i(err_code_i), .led_green_o(led_green_o),
      .led_red_o(led_red_o), .state_o(state_o), .ctrl_o(ctrl_o));

   fieldbus_peer_model fieldbus_peer_model_inst (
      .sys_clk_i(sys_clk_i), .frame_seen_o(frame_seen_i), .soc_rx_o(soc_rx_i),
      .cmd_o(cmd_i), .mn_fail_o(mn_fail_i));

   task automatic chk(input logic [6:0] got, input logic [6:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   // Reset with static role and mode applied while held
   task automatic do_reset(input logic role, input logic eth);
      rst_i = 1'b1;
      managing_node_role_i = role;
      eth_mode_i = eth;
      tick(8);
      chk({led_green_o, led_red_o, state_o[4:0]}, 7'h01, "reset");
      rst_i = 1'b0;
   endtask

   // Event, then state one edge later and controls one edge after that
   task automatic step(input logic [6:0] ev, input logic [6:0] st, input logic [6:0] ct);
      fieldbus_peer_model_inst.pulse(ev);
      chk(state_o, st, "state");
      tick(1);
      chk(ctrl_o, ct, "ctrl");
   endtask

   task automatic wait_state(input logic [6:0] st, input int lim);
      int i;
      for (i = 0; i < lim && state_o !== st; i++)
         tick(1);
      chk(state_o, st, "wait state");
   endtask

   // Lit cycles of one LED over a window, after a settling skip
   task automatic span(input int skip, input int win, input bit red, input int exp);
      int n;
      n = 0;
      tick(skip);
      repeat (win)
      begin
         tick(1);
         n += (red ? led_red_o : led_green_o) === 1'b1;
      end
      chk(7'(n / T), 7'(exp / T), red ? "red lit time" : "green lit time");
   endtask

   task automatic test_cn;
      do_reset(1'b0, 1'b0);
      tick(1);
      chk({led_green_o, led_red_o}, 7'h00, "inactive leds");
      step(EV_FRAME, 7'h04, 7'h20);
      span(28 * T, 28 * T, 1'b0, 4 * T);
      step(EV_SOC, 7'h08, 7'h28);
      span(36 * T, 36 * T, 1'b0, 8 * T);
      fieldbus_peer_model_inst.set_fail(1'b1);
      tick(2);
      chk(led_red_o, 7'h01, "manager failed");
      fieldbus_peer_model_inst.set_fail(1'b0);
      step(EV_RDY, 7'h10, 7'h0c);
      span(44 * T, 44 * T, 1'b0, 12 * T);
      step(EV_OP, 7'h20, 7'h0e);
      chk(led_green_o, 7'h01, "running green");
      step(EV_STOP, 7'h40, 7'h00);
      span(8 * T, 8 * T, 1'b0, 4 * T);
      fieldbus_peer_model_inst.pulse(EV_OP);
      chk(state_o, 7'h40, "halted holds");
      step(EV_PRE, 7'h08, 7'h28);
      $display("test controlled walk done");
   endtask

   task automatic test_cn_timeout;
      do_reset(1'b0, 1'b0);
      wait_state(7'h02, 200);
      tick(1);
      chk(ctrl_o, 7'h40, "plain ctrl");
      span(2 * T, 2 * T, 1'b0, T);
      step(EV_FRAME, 7'h04, 7'h20);
      $display("test controlled timeout done");
   endtask

   task automatic test_mn;
      do_reset(1'b1, 1'b0);
      fieldbus_peer_model_inst.pulse(EV_FRAME);
      tick(100);
      chk(state_o, 7'h01, "blocked manager");
      do_reset(1'b1, 1'b0);
      wait_state(7'h04, 200);
      tick(1);
      chk(ctrl_o, 7'h10, "reduced cycle");
      fieldbus_peer_model_inst.pulse(EV_SOC);
      chk(state_o, 7'h04, "soc ignored");
      step(EV_CYC, 7'h08, 7'h09);
      step(EV_RDY, 7'h10, 7'h0d);
      step(EV_OP, 7'h20, 7'h0e);
      fieldbus_peer_model_inst.pulse(EV_STOP);
      chk(state_o, 7'h20, "no halt as manager");
      $display("test managing role done");
   endtask

   task automatic test_eth_err;
      do_reset(1'b0, 1'b1);
      tick(2);
      chk(led_green_o, 7'h01, "ethernet mode green");
      do_reset(1'b0, 1'b0);
      sys_err_i = 1'b1;
      tick(2);
      chk(led_red_o, 7'h01, "error start lit");
      span(0, 88 * T - 1, 1'b1, 30 * T - 1);
      sys_err_i = 1'b0;
      $display("test mode and error done");
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      test_cn();
      test_cn_timeout();
      test_mn();
      test_eth_err();
      summarize();
   end

   // Whole run is under two thousand cycles
   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      mismatches++;
      summarize();
   end
endmodule // tb_fieldbus_node_led
